// file: rtl/cps_pkg.sv
package cps_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  SYSCFG_OFFSET = 8'hf0;
    localparam logic [15:0] SYSCFG_RESET  = 16'h0000;
    localparam logic [7:0]  STATUS_OFFSET = 8'hf4;
    localparam int POWER_SAVE_ENABLE_POS  = 15;
    localparam int MCS_POS   = 14;
    localparam int DSD_POS   = 13;
    localparam int PWD_POS   = 12;
    localparam int SFS_POS   = 11;
    localparam int SOD_POS   = 10;
    localparam int PFS_POS   = 9;
    localparam int POD_POS   = 8;
    localparam int DIV_LSB   = 0;
    localparam int DIV_W     = 3;
    localparam logic [15:0] SYSCFG_WMASK = 16'hff07;
    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] CNT_RESET = 7'h00;

    typedef enum logic [1:0] {CPS_IDLE, CPS_ACK} cps_bus_t;

    // Half period of the divided clock, in input clock cycles minus one
    function automatic logic [CNT_W-1:0] cps_half(input logic [DIV_W-1:0] sel);
        logic [CNT_W-1:0] r;
        r = 7'h00;
        unique case (sel)
            3'h0: r = 7'h00;
            3'h1: r = 7'h01;
            3'h2: r = 7'h03;
            3'h3: r = 7'h07;
            3'h4: r = 7'h0f;
            3'h5: r = 7'h1f;
            3'h6: r = 7'h3f;
            3'h7: r = 7'h7f;
        endcase
        return r;
    endfunction
endpackage

// file: rtl/cps_divider.sv
module cps_divider
    import cps_pkg::*;
(
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset_n,
    // Control
    input  wire logic [DIV_W-1:0] div_sel,
    // Divided clock level
    output logic                  div_clk
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             clk_ff;
    logic             nxt_clk;
    logic [CNT_W-1:0] half;

    always_comb begin
        half    = cps_half(div_sel);
        nxt_cnt = CNT_W'(cnt_ff + 7'h01);
        nxt_clk = clk_ff;
        if (cnt_ff >= half) begin
            nxt_cnt = CNT_RESET;
            nxt_clk = ~clk_ff;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= CNT_RESET;
            clk_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            clk_ff <= nxt_clk;
        end
    end

    assign div_clk = clk_ff;
endmodule

// file: rtl/cps_top.sv
// Functional notes
// - Internal clock equals crystal rate; duty 45 to 55 percent.
// - Power-on reset returns clock generation to its initial state.
// - Four configuration bits set enable and rate of primary and secondary outputs independently.
// - Configuration register at 0f0h resets to all zeros.
// - Power save bit 15 divides operating clock by divide field.
// - Hardware interrupts clear power save; software ones do not.
// - Interrupt return never restores the power save bit.
// - Bit 14 makes select 0 cover whole range; selects 1,2 freed.
// - Bit 13 chooses data strobe when set, data enable when clear.
// - Bit 12 enables the pulse width demodulator.
// - Bit 11 puts secondary output at crystal rate, else divided.
// - Bit 10 holds secondary output low, else it toggles.
// - Bit 9 puts primary output at crystal rate, else divided.
// - Primary output keeps toggling during bus grant; reset holds it low.
// - Divide field with enable/frequency bits sets output power-save rate.
module cps_top
    import cps_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Interrupt sources from the core
    input  wire logic        hw_interrupt,
    input  wire logic        interrupt_return_instruction,
    // Clock outputs
    output logic             clkout_primary,
    output logic             clkout_secondary,
    output logic             operating_clk_en,
    // Configuration outputs
    output logic             single_midrange_select,
    output logic             strobe_mode_select,
    output logic             pwd_enable,
    output logic             power_save_enable
);
    // ------------------------------------------------------------
    // Interrupt input synchroniser
    // ------------------------------------------------------------
    logic irq_s1_ff;
    logic irq_s2_ff;
    logic irq_d_ff;
    logic irq_rise;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_s1_ff <= 1'b0;
            irq_s2_ff <= 1'b0;
            irq_d_ff  <= 1'b0;
        end else begin
            irq_s1_ff <= hw_interrupt;
            irq_s2_ff <= irq_s1_ff;
            irq_d_ff  <= irq_s2_ff;
        end
    end

    assign irq_rise = irq_s2_ff & ~irq_d_ff;

    // ------------------------------------------------------------
    // Avalon slave and configuration register
    // ------------------------------------------------------------
    cps_bus_t    bus_ff;
    cps_bus_t    nxt_bus;
    logic [15:0] cfg_ff;
    logic [15:0] nxt_cfg;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        wait_ff;
    logic        nxt_wait;
    logic        req;
    logic [15:0] wval;
    logic        div_clk;

    assign req = avs_read | avs_write;

    always_comb begin
        nxt_bus   = bus_ff;
        nxt_cfg   = cfg_ff;
        nxt_rdata = rdata_ff;
        nxt_wait  = 1'b1;
        wval      = cfg_ff;
        if (avs_byteenable[0]) begin
            wval[7:0] = avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
            wval[15:8] = avs_writedata[15:8];
        end
        unique case (bus_ff)
            CPS_IDLE: begin
                if (req) begin
                    nxt_bus  = CPS_ACK;
                    nxt_wait = 1'b0;
                    nxt_rdata = 32'h0000_0000;
                    if (avs_read && avs_address == SYSCFG_OFFSET) begin
                        nxt_rdata = {16'h0000, cfg_ff};
                    end else if (avs_read && avs_address == STATUS_OFFSET) begin
                        nxt_rdata = {29'h0000_0000, clkout_secondary, clkout_primary, div_clk};
                    end
                end
            end
            CPS_ACK: begin
                nxt_bus = CPS_IDLE;
                // Write lands at the edge where waitrequest is seen low
                if (avs_write && avs_address == SYSCFG_OFFSET) begin
                    nxt_cfg = wval & SYSCFG_WMASK;
                end
            end
        endcase
        // Hardware interrupt wins over a software write of the same cycle
        if (irq_rise) begin
            nxt_cfg[POWER_SAVE_ENABLE_POS] = 1'b0;
        end
        // Interrupt return leaves the bit as it is
        if (interrupt_return_instruction) begin
            nxt_cfg[POWER_SAVE_ENABLE_POS] = nxt_cfg[POWER_SAVE_ENABLE_POS];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bus_ff   <= CPS_IDLE;
            cfg_ff   <= SYSCFG_RESET;
            rdata_ff <= 32'h0000_0000;
            wait_ff  <= 1'b1;
        end else begin
            bus_ff   <= nxt_bus;
            cfg_ff   <= nxt_cfg;
            rdata_ff <= nxt_rdata;
            wait_ff  <= nxt_wait;
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;

    // ------------------------------------------------------------
    // Clock generation
    // ------------------------------------------------------------
    logic div_d_ff;
    logic div_edge;
    logic pll_ff;
    logic nxt_pll;
    logic pa_ff;
    logic nxt_pa;
    logic sb_ff;
    logic nxt_sb;
    logic op_ff;
    logic nxt_op;
    logic [DIV_W-1:0] div_sel;

    // Divide field applies only in power save; otherwise select 0, toggling every cycle
    assign div_sel = cfg_ff[POWER_SAVE_ENABLE_POS] ? cfg_ff[DIV_LSB +: DIV_W] : 3'h0;

    cps_divider cps_divider_inst (
        .clock   (clock),
        .reset_n (reset_n),
        .div_sel (div_sel),
        .div_clk (div_clk)
    );

    // The crystal-rate clock is modelled as a 50 percent toggle
    always_comb begin
        nxt_pll = ~pll_ff;
        nxt_op  = div_clk & ~div_d_ff;
        nxt_pa  = cfg_ff[PFS_POS] ? nxt_pll : div_clk;
        if (cfg_ff[POD_POS]) begin
            nxt_pa = 1'b0;
        end
        nxt_sb  = cfg_ff[SFS_POS] ? nxt_pll : div_clk;
        if (cfg_ff[SOD_POS]) begin
            nxt_sb = 1'b0;
        end
    end

    assign div_edge = div_clk ^ div_d_ff;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pll_ff   <= 1'b0;
            div_d_ff <= 1'b0;
            pa_ff    <= 1'b0;
            sb_ff    <= 1'b0;
            op_ff    <= 1'b0;
        end else begin
            pll_ff   <= nxt_pll;
            div_d_ff <= div_clk;
            pa_ff    <= nxt_pa;
            sb_ff    <= nxt_sb;
            op_ff    <= nxt_op;
        end
    end

    // Primary output toggles also under bus grant; only reset or bit 8 (POD) stops it
    assign clkout_primary   = pa_ff;
    assign clkout_secondary = sb_ff;
    assign operating_clk_en = op_ff;

    // ------------------------------------------------------------
    // Configuration fan-out
    // ------------------------------------------------------------
    assign single_midrange_select = cfg_ff[MCS_POS];
    assign strobe_mode_select     = cfg_ff[DSD_POS];
    assign pwd_enable             = cfg_ff[PWD_POS];
    assign power_save_enable      = cfg_ff[POWER_SAVE_ENABLE_POS];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_reset_val;
        @(posedge clock) disable iff (!reset_n)
        $rose(reset_n) |-> cfg_ff == SYSCFG_RESET;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("cfg not zero");

    property p_irq_clear;
        @(posedge clock) disable iff (!reset_n)
        irq_rise |=> !cfg_ff[POWER_SAVE_ENABLE_POS];
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("power_save_enable not cleared");

    property p_interrupt_return_instruction;
        @(posedge clock) disable iff (!reset_n)
        (interrupt_return_instruction && !cfg_ff[POWER_SAVE_ENABLE_POS] && !avs_write) |=>
            !cfg_ff[POWER_SAVE_ENABLE_POS];
    endproperty
    a_interrupt_return_instruction: assert property (p_interrupt_return_instruction) else $error("power_save_enable restored");

    property p_sec_off;
        @(posedge clock) disable iff (!reset_n)
        cfg_ff[SOD_POS] [*2] |-> !clkout_secondary;
    endproperty
    a_sec_off: assert property (p_sec_off) else $error("secondary not low");

    property p_pri_off;
        @(posedge clock) disable iff (!reset_n)
        cfg_ff[POD_POS] [*2] |-> !clkout_primary;
    endproperty
    a_pri_off: assert property (p_pri_off) else $error("primary not low");

    property p_pri_fast;
        @(posedge clock) disable iff (!reset_n)
        (cfg_ff[PFS_POS] && !cfg_ff[POD_POS]) [*3] |-> clkout_primary != $past(clkout_primary);
    endproperty
    a_pri_fast: assert property (p_pri_fast) else $error("primary not fast");

    property p_sec_fast;
        @(posedge clock) disable iff (!reset_n)
        (cfg_ff[SFS_POS] && !cfg_ff[SOD_POS]) [*3] |-> clkout_secondary != $past(clkout_secondary);
    endproperty
    a_sec_fast: assert property (p_sec_fast) else $error("secondary not fast");

    property p_ack;
        @(posedge clock) disable iff (!reset_n)
        (req && avs_waitrequest) |-> ##[1:2] !avs_waitrequest;
    endproperty
    a_ack: assert property (p_ack) else $error("no bus answer");

    property p_fanout;
        @(posedge clock) disable iff (!reset_n)
        1'b1 |-> (single_midrange_select == cfg_ff[MCS_POS]) &&
                 (strobe_mode_select == cfg_ff[DSD_POS]) && (pwd_enable == cfg_ff[PWD_POS]);
    endproperty
    a_fanout: assert property (p_fanout) else $error("fanout mismatch");

    // Low write half, kept for comparison one cycle later
    logic [15:0] wr_low;
    assign wr_low = avs_writedata[15:0];

    property p_write_lands;
        @(posedge clock) disable iff (!reset_n)
        (avs_write && !avs_waitrequest && avs_address == SYSCFG_OFFSET &&
         avs_byteenable[1:0] == 2'h3 && !irq_rise) |=>
            cfg_ff == ($past(wr_low) & SYSCFG_WMASK);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write lost");

    property p_ack_once;
        @(posedge clock) disable iff (!reset_n)
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack too long");

    property p_op_pulse;
        @(posedge clock) disable iff (!reset_n)
        operating_clk_en |=> !operating_clk_en;
    endproperty
    a_op_pulse: assert property (p_op_pulse) else $error("op pulse too long");

    property p_op_rise;
        @(posedge clock) disable iff (!reset_n)
        (div_edge && div_clk) |=> operating_clk_en;
    endproperty
    a_op_rise: assert property (p_op_rise) else $error("op pulse missing");

    property p_pll_run;
        @(posedge clock) disable iff (!reset_n)
        $past(reset_n) |-> pll_ff != $past(pll_ff);
    endproperty
    a_pll_run: assert property (p_pll_run) else $error("pll stalled");
endmodule

// file: test/cps_clock_monitor.sv
module cps_toggle_counter (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // Control
    input  wire logic       clear,
    // Observed clock output
    input  wire logic       sense,
    // Result
    output logic [7:0]      toggles
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_ff;
    // ------------------------------------------------------------
    // Counts level changes of a clock output seen by system logic
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            last_ff <= 1'b0;
            toggles <= 8'h00;
        end else begin
            last_ff <= sense;
            if (clear)
                toggles <= 8'h00;
            else if (sense != last_ff)
                toggles <= toggles + 8'h01;
        end
    end
endmodule

// file: test/cps_top_bench.sv
module cps_top_bench;
    import cps_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [15:0] cfg; logic [7:0] prim; logic [7:0] sec;} cps_row_t;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        hw_interrupt = 1'b0;
    logic        interrupt_return_instruction = 1'b0;
    logic        clkout_primary, clkout_secondary, operating_clk_en;
    logic        single_midrange_select, strobe_mode_select, pwd_enable, power_save_enable;
    logic        clear = 1'b0;
    logic [7:0]  prim_cnt, sec_cnt, op_cnt;
    logic [3:0]  cfg_outs;
    logic [31:0] q;
    int          n_errors = 0;
    int          tests_run = 0;
    cps_row_t    rows [8] = '{
        '{16'h0600, 8'h40, 8'h00}, '{16'h0900, 8'h00, 8'h40},
        '{16'h82f9, 8'h40, 8'h20}, '{16'h8802, 8'h10, 8'h40},
        '{16'h8003, 8'h08, 8'h08}, '{16'h8107, 8'h00, 8'h00},
        '{16'h7500, 8'h00, 8'h00}, '{16'h0a00, 8'h40, 8'h40}};

    // Bench clock stands in for an external oscillator on the crystal input
    initial begin
        forever #12.5 clock = ~clock;
    end

    cps_top cps_top_inst (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .hw_interrupt(hw_interrupt),
        .interrupt_return_instruction(interrupt_return_instruction),
        .clkout_primary(clkout_primary), .clkout_secondary(clkout_secondary),
        .operating_clk_en(operating_clk_en), .single_midrange_select(single_midrange_select),
        .strobe_mode_select(strobe_mode_select), .pwd_enable(pwd_enable),
        .power_save_enable(power_save_enable));
    cps_toggle_counter cps_toggle_counter_inst (.clock(clock), .reset_n(reset_n),
        .clear(clear), .sense(clkout_primary), .toggles(prim_cnt));
    cps_toggle_counter cps_toggle_counter_inst_b (.clock(clock), .reset_n(reset_n),
        .clear(clear), .sense(clkout_secondary), .toggles(sec_cnt));
    cps_toggle_counter cps_toggle_counter_inst_c (.clock(clock), .reset_n(reset_n),
        .clear(clear), .sense(operating_clk_en), .toggles(op_cnt));

    assign cfg_outs = {power_save_enable, single_midrange_select, strobe_mode_select, pwd_enable};

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        if (n_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Request held until the edge where waitrequest is sampled low
    task automatic xfer(input logic [7:0] a, input logic wr, input logic [15:0] d,
                        input logic [3:0] be, output logic [31:0] rd);
        int n;
        @(posedge clock);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= {16'h0000, d};
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            n_errors++;
            print_verdict();
        end
    endtask

    task automatic check_count(input string name, input logic [7:0] seen, input logic [7:0] e);
        check(name, 32'(seen + 8'h01 >= e && seen <= e + 8'h01), 32'h1);
    endtask

    // Lets the outputs settle, clears the counters, then counts for 64 cycles
    task automatic measure();
        repeat (260) @(posedge clock);
        clear <= 1'b1;
        @(posedge clock);
        clear <= 1'b0;
        repeat (64) @(posedge clock);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clock);
        check("wait_in_reset", 32'(avs_waitrequest), 32'h1);
        check("prim_in_reset", 32'(clkout_primary), 32'h0);
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        xfer(SYSCFG_OFFSET, 1'b0, 16'h0, 4'hf, q);
        check("cfg_reset", q, 32'h0);
        foreach (rows[i]) begin
            xfer(SYSCFG_OFFSET, 1'b1, rows[i].cfg, 4'h3, q);
            xfer(SYSCFG_OFFSET, 1'b0, 16'h0, 4'hf, q);
            check("cfg_read", q, {16'h0000, rows[i].cfg & SYSCFG_WMASK});
            check("cfg_hi", 32'(cfg_outs[3:2]), 32'(rows[i].cfg[15:14]));
            check("cfg_mid", 32'(cfg_outs[1:0]), 32'(rows[i].cfg[13:12]));
            measure();
            check_count("prim_toggles", prim_cnt, rows[i].prim);
            check_count("sec_toggles", sec_cnt, rows[i].sec);
            if (rows[i].cfg[8]) begin
                check("prim_low", 32'(clkout_primary), 32'h0);
            end
            if (rows[i].cfg[10]) begin
                check("sec_low", 32'(clkout_secondary), 32'h0);
            end
        end
        // Unmapped place and byte lanes
        xfer(8'h10, 1'b1, 16'hffff, 4'hf, q);
        xfer(8'h10, 1'b0, 16'h0, 4'hf, q);
        check("unmapped_read", q, 32'h0);
        xfer(SYSCFG_OFFSET, 1'b1, 16'h8105, 4'h1, q);
        xfer(SYSCFG_OFFSET, 1'b0, 16'h0, 4'hf, q);
        check("low_lane", q, 32'h00000a05);
        // Status: both outputs at crystal rate match, then both held low
        xfer(STATUS_OFFSET, 1'b0, 16'h0, 4'hf, q);
        check("status_pair", 32'({q[31:3], q[2] ^ q[1]}), 32'h0);
        xfer(SYSCFG_OFFSET, 1'b1, 16'h0500, 4'h3, q);
        xfer(STATUS_OFFSET, 1'b0, 16'h0, 4'hf, q);
        check("status_off", q & 32'hffff_fffe, 32'h0);
        // Operating clock pulses once per divided period
        xfer(SYSCFG_OFFSET, 1'b1, 16'h8002, 4'h3, q);
        measure();
        check_count("op_pulses", op_cnt, 8'h10);
        // Return from interrupt alone keeps power save
        xfer(SYSCFG_OFFSET, 1'b1, 16'h8001, 4'h3, q);
        interrupt_return_instruction <= 1'b1;
        @(posedge clock);
        interrupt_return_instruction <= 1'b0;
        repeat (4) @(posedge clock);
        check("power_save_enable_kept", 32'(power_save_enable), 32'h1);
        // Hardware interrupt clears it, return does not restore it
        hw_interrupt <= 1'b1;
        repeat (6) @(posedge clock);
        hw_interrupt <= 1'b0;
        check("power_save_enable_cleared", 32'(power_save_enable), 32'h0);
        interrupt_return_instruction <= 1'b1;
        @(posedge clock);
        interrupt_return_instruction <= 1'b0;
        xfer(SYSCFG_OFFSET, 1'b0, 16'h0, 4'hf, q);
        check("power_save_enable_after_return", q, 32'h00000001);
        // Second reset in mid-run
        xfer(SYSCFG_OFFSET, 1'b1, 16'h7a03, 4'h3, q);
        reset_n <= 1'b0;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        xfer(SYSCFG_OFFSET, 1'b0, 16'h0, 4'hf, q);
        check("cfg_rereset", q, 32'h0);
        print_verdict();
    end
endmodule
